/* design/apc_pkg.sv */
// package for the converter port and clock control block
// assumes a 100 MHz reference clock that also serves as the oscillator period
package apc_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_PORT_LEVEL   = 8'h05; // pin levels with analog pins masked
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h0c; // completion flag register
	localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h8c; // completion enable register
	localparam logic [7:0] IDX_RESULT_HIGH  = 8'h1e; // result_high_byte
	localparam logic [7:0] IDX_RESULT_LOW   = 8'h9e; // result_low_byte
	localparam logic [7:0] IDX_CTRL_ZERO    = 8'h1f; // conv_control_zero
	localparam logic [7:0] IDX_CTRL_ONE     = 8'h9f; // conv_control_one / adc_config_one

	// conv_control_zero fields
	localparam int C0_SRC_HI  = 7; // clk_src_sel upper bit
	localparam int C0_SRC_LO  = 6; // clk_src_sel lower bit
	localparam int C0_CH_HI   = 5; // channel_select upper bit
	localparam int C0_CH_LO   = 3; // channel_select lower bit
	localparam int C0_GO      = 2; // go / done flag
	localparam int C0_ON      = 0; // converter_on
	// conv_control_one fields
	localparam int C1_FMT     = 7; // result_format_sel
	localparam int C1_HALF    = 6; // clk_half_sel
	localparam int C1_CFG_HI  = 3; // port_cfg upper bit
	// flag and enable bit position
	localparam int IRQ_BIT    = 6; // conv_irq_flag / conv_irq_enable

	// values after reset
	localparam logic [7:0] RST_BYTE = 8'h00; // every control field clears
	localparam logic [4:0] RST_ANALOG = 5'h1f; // all five channels analog

	// conversion timing in bit periods
	localparam logic [3:0] CONV_TADS    = 4'h9; // bit periods per conversion
	localparam logic [3:0] HOLDOFF_TADS = 4'h2; // recovery before acquisition
	// internal rc bit period
	localparam int CLK_NS      = 10;   // reference clock period
	localparam int RC_TAD_NS   = 4000; // typical rc bit period
	localparam int RC_TAD_CYC  = RC_TAD_NS / CLK_NS; // rc period in clocks
	localparam logic [1:0] SRC_RC = 2'h3; // source code of the rc clock

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0; // access done
	localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

	// sequencer states
	typedef enum logic [1:0] {
		APC_OFF     = 2'b00, // converter off
		APC_ACQ     = 2'b01, // acquiring, hold capacitor connected
		APC_CONV    = 2'b10, // converting
		APC_HOLDOFF = 2'b11  // recovery, capacitor disconnected
	} apc_state_t;

	// port configuration decode: {vref_neg, vref_pos, analog mask[4:0]}
	function automatic logic [6:0] apc_cfg_decode(input logic [3:0] cfg);
		logic [6:0] d;
		d = 7'h1f;
		case (cfg)
			4'h0, 4'h2, 4'h9: d = 7'h1f;
			4'h1, 4'h3, 4'ha: d = 7'h37;
			4'h4:             d = 7'h0b;
			4'h5:             d = 7'h23;
			4'h6, 4'h7:       d = 7'h00;
			4'h8, 4'hb, 4'hc: d = 7'h73;
			4'hd:             d = 7'h63;
			4'he:             d = 7'h01;
			4'hf:             d = 7'h61;
			default:          d = 7'h1f;
		endcase
		return d;
	endfunction : apc_cfg_decode

endpackage : apc_pkg

/* design/apc_tad_gen.sv */
// bit period tick generator for the converter
// assumes i_ref_clk is the oscillator; restart realigns the period
`timescale 1ns/10ps
module apc_tad_gen #(
	parameter int RC_CYC = apc_pkg::RC_TAD_CYC // rc bit period in clocks
) (
	input  wire logic       i_ref_clk,   // reference clock
	input  wire logic       i_reset_n,   // async reset, active low
	input  wire logic       i_clk_en,    // freezes state when low
	input  wire logic       i_restart,   // start a fresh bit period
	input  wire logic       i_half_sel,  // clk_half_sel
	input  wire logic [1:0] i_src_sel,   // clk_src_sel
	output logic            o_tick       // one pulse per bit period
);
	logic [15:0] cnt_r;  // clocks elapsed in this period
	logic [15:0] div;    // clocks per bit period
	logic [3:0]  shift;  // power of two for oscillator settings

	always_comb begin
		shift = 4'({1'b0, i_src_sel, i_half_sel}) + 4'h1;
		if (i_src_sel == apc_pkg::SRC_RC) begin
			div = 16'(RC_CYC);
		end else begin
			div = 16'h1 << shift;
		end
	end

	// period counter and tick
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_r  <= 16'h0;
			o_tick <= 1'b0;
		end else if (i_clk_en) begin
			if (i_restart) begin
				cnt_r  <= 16'h0;
				o_tick <= 1'b0;
			end else if (cnt_r >= div - 16'h1) begin
				cnt_r  <= 16'h0;
				o_tick <= 1'b1;
			end else begin
				cnt_r  <= cnt_r + 16'h1;
				o_tick <= 1'b0;
			end
		end
	end
endmodule : apc_tad_gen

/* design/apc_top.sv */
// converter port and clock control, axi4-lite register slave
// assumes the analog front end returns the held code for o_sample_ch
// Summary of operation
// - format 1: right justify, high six zero
// - format 0: left justify, low six zero
// - halving bit doubles oscillator divider
// - control one bits 5:4 read zero
// - decode all-analog, all-digital, channel-0-only codes
// - channel 3/2 become external references
// - report analog and reference pin counts
// - completion loads result, clears go, flags
// - conversion lasts exactly nine bit periods
// - two bit periods holdoff, capacitor disconnected
// - divider 2..64 or internal rc
// - rc bit period modelled as 4 us
// - sampling ignores pin direction
// - port reads zero on analog pins
// - clearing go aborts, result kept
// - after abort, holdoff then acquisition
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module apc_top #(
	parameter int AW = 12 // axi address width
) (
	input  wire logic          i_ref_clk,       // 100 MHz clock
	input  wire logic          i_reset_n,       // async reset, active low
	input  wire logic          i_clk_en,        // freezes all state when low
	input  wire logic [AW-1:0] i_awaddr,        // write address
	input  wire logic          i_awvalid,       // write address valid
	output logic               o_awready,       // write address ready
	input  wire logic [31:0]   i_wdata,         // write data
	input  wire logic [3:0]    i_wstrb,         // write strobes
	input  wire logic          i_wvalid,        // write data valid
	output logic               o_wready,        // write data ready
	output logic [1:0]         o_bresp,         // write response
	output logic               o_bvalid,        // write response valid
	input  wire logic          i_bready,        // write response ready
	input  wire logic [AW-1:0] i_araddr,        // read address
	input  wire logic          i_arvalid,       // read address valid
	output logic               o_arready,       // read address ready
	output logic [31:0]        o_rdata,         // read data
	output logic [1:0]         o_rresp,         // read response
	output logic               o_rvalid,        // read data valid
	input  wire logic          i_rready,        // read data ready
	input  wire logic [4:0]    i_pin_level,     // digital level of the five pins
	input  wire logic [9:0]    i_sample_code,   // front end code of o_sample_ch
	output logic [2:0]         o_sample_ch,     // channel_select to the mux
	output logic               o_hold_connect,  // hold_capacitor on input
	output logic               o_conv_busy,     // conversion running
	output logic [4:0]         o_analog_sel,    // pins used as analog inputs
	output logic               o_vref_pos_ext,  // channel 3 is positive ref
	output logic               o_vref_neg_ext,  // channel 2 is negative ref
	output logic [2:0]         o_analog_count,  // analog input count
	output logic [1:0]         o_ref_count      // external reference count
);
	// register fields
	logic [1:0]  src_sel_r;   // clk_src_sel
	logic [2:0]  chan_r;      // channel_select
	logic        go_r;        // go / done flag
	logic        on_r;        // converter_on
	logic        fmt_r;       // result_format_sel
	logic        half_r;      // clk_half_sel
	logic [3:0]  pcfg_r;      // port_cfg
	logic        irq_flag_r;  // conv_irq_flag
	logic        irq_en_r;    // conv_irq_enable
	logic [7:0]  res_hi_r;    // result_high_byte
	logic [7:0]  res_lo_r;    // result_low_byte
	logic [9:0]  held_r;      // code captured on the hold capacitor
	// sequencer
	apc_pkg::apc_state_t state_r; // current state
	logic [3:0]  tad_cnt_r;   // bit periods counted in state
	logic        tick;        // bit period pulse
	// axi write side
	logic [AW-1:0] awaddr_r;  // latched write address
	logic          aw_hold_r; // write address held
	logic [31:0]   wdata_r;   // latched write data
	logic [3:0]    wstrb_r;   // latched strobes
	logic          w_hold_r;  // write data held
	logic          do_wr;     // execute the write now
	logic          wr_ok;     // write hits a mapped register
	// decoded strobes
	logic        wr_c0;       // write to conv_control_zero
	logic        wr_c1;       // write to conv_control_one
	logic        start;       // conversion starts
	logic        done;        // conversion completes
	logic        abort;       // conversion aborted
	logic        restart;     // realign bit period
	logic [6:0]  dec;         // decoded port configuration
	logic [31:0] rd_mux;      // read value
	logic        rd_ok;       // read hits a mapped register

	// true when a byte address selects a register index
	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
		return (a[1:0] == 2'h0) && (a[AW-1:2] == (AW-2)'(idx));
	endfunction : hit

	assign do_wr = aw_hold_r && w_hold_r && !o_bvalid;
	assign wr_ok = hit(awaddr_r, apc_pkg::IDX_PORT_LEVEL) || hit(awaddr_r, apc_pkg::IDX_IRQ_STATUS)
		|| hit(awaddr_r, apc_pkg::IDX_IRQ_ENABLE) || hit(awaddr_r, apc_pkg::IDX_RESULT_HIGH)
		|| hit(awaddr_r, apc_pkg::IDX_RESULT_LOW) || wr_c0 || wr_c1;
	assign wr_c0 = hit(awaddr_r, apc_pkg::IDX_CTRL_ZERO);
	assign wr_c1 = hit(awaddr_r, apc_pkg::IDX_CTRL_ONE);
	assign start = do_wr && wr_c0 && i_wstrb_ok(wstrb_r) && wdata_r[apc_pkg::C0_GO]
		&& on_r && (state_r == apc_pkg::APC_ACQ);
	assign done  = (state_r == apc_pkg::APC_CONV) && tick && (tad_cnt_r == apc_pkg::CONV_TADS - 4'h1);
	assign abort = (state_r == apc_pkg::APC_CONV) && !done && do_wr && wr_c0
		&& i_wstrb_ok(wstrb_r) && !wdata_r[apc_pkg::C0_GO];
	assign restart = start || done || abort;
	assign dec = apc_pkg::apc_cfg_decode(pcfg_r);

	// only the low byte lane carries register data
	function automatic logic i_wstrb_ok(input logic [3:0] s);
		return s[0];
	endfunction : i_wstrb_ok

	// bit period source
	apc_tad_gen u_tad (
		.i_ref_clk  (i_ref_clk),
		.i_reset_n  (i_reset_n),
		.i_clk_en   (i_clk_en),
		.i_restart  (restart),
		.i_half_sel (half_r),
		.i_src_sel  (src_sel_r),
		.o_tick     (tick)
	);

	// read multiplexer
	always_comb begin
		rd_mux = 32'h0;
		rd_ok  = 1'b1;
		if (hit(i_araddr, apc_pkg::IDX_CTRL_ZERO)) begin
			rd_mux[7:0] = {src_sel_r, chan_r, go_r, 1'b0, on_r};
		end else if (hit(i_araddr, apc_pkg::IDX_CTRL_ONE)) begin
			rd_mux[7:0] = {fmt_r, half_r, 2'h0, pcfg_r};
		end else if (hit(i_araddr, apc_pkg::IDX_RESULT_HIGH)) begin
			rd_mux[7:0] = res_hi_r;
		end else if (hit(i_araddr, apc_pkg::IDX_RESULT_LOW)) begin
			rd_mux[7:0] = res_lo_r;
		end else if (hit(i_araddr, apc_pkg::IDX_IRQ_STATUS)) begin
			rd_mux[apc_pkg::IRQ_BIT] = irq_flag_r;
		end else if (hit(i_araddr, apc_pkg::IDX_IRQ_ENABLE)) begin
			rd_mux[apc_pkg::IRQ_BIT] = irq_en_r;
		end else if (hit(i_araddr, apc_pkg::IDX_PORT_LEVEL)) begin
			rd_mux[4:0] = i_pin_level & ~o_analog_sel;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// axi write channels and response
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= apc_pkg::RESP_OKAY;
		end else if (i_clk_en) begin
			// address and data taken in either order
			if (i_awvalid && o_awready) begin
				awaddr_r  <= i_awaddr;
				aw_hold_r <= 1'b1;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				wdata_r  <= i_wdata;
				wstrb_r  <= i_wstrb;
				w_hold_r <= 1'b1;
				o_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
				o_bvalid  <= 1'b1;
				o_bresp   <= wr_ok ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// axi read channel, answer one cycle after the address
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= apc_pkg::RESP_OKAY;
		end else if (i_clk_en) begin
			if (i_arvalid && o_arready) begin
				o_arready <= 1'b0;
				o_rvalid  <= 1'b1;
				o_rdata   <= rd_mux;
				o_rresp   <= rd_ok ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid  <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	// configuration registers
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{fmt_r, half_r, pcfg_r} <= 6'(apc_pkg::RST_BYTE);
			{src_sel_r, chan_r, on_r} <= 6'(apc_pkg::RST_BYTE);
			irq_en_r <= 1'b0;
		end else if (i_clk_en && do_wr && i_wstrb_ok(wstrb_r)) begin
			if (wr_c1) begin
				fmt_r  <= wdata_r[apc_pkg::C1_FMT];
				half_r <= wdata_r[apc_pkg::C1_HALF];
				pcfg_r <= wdata_r[apc_pkg::C1_CFG_HI:0];
			end
			if (wr_c0) begin
				src_sel_r <= wdata_r[apc_pkg::C0_SRC_HI:apc_pkg::C0_SRC_LO];
				chan_r    <= wdata_r[apc_pkg::C0_CH_HI:apc_pkg::C0_CH_LO];
				on_r      <= wdata_r[apc_pkg::C0_ON];
			end
			if (hit(awaddr_r, apc_pkg::IDX_IRQ_ENABLE)) begin
				irq_en_r <= wdata_r[apc_pkg::IRQ_BIT];
			end
		end
	end

	// port decode outputs
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_analog_sel   <= apc_pkg::RST_ANALOG;
			o_vref_pos_ext <= 1'b0;
			o_vref_neg_ext <= 1'b0;
			o_analog_count <= 3'h5;
			o_ref_count    <= 2'h0;
		end else if (i_clk_en) begin
			o_analog_sel   <= dec[4:0];
			o_vref_pos_ext <= dec[5];
			o_vref_neg_ext <= dec[6];
			o_analog_count <= 3'(dec[0] + dec[1] + dec[2] + dec[3] + dec[4]);
			o_ref_count    <= 2'(dec[5] + dec[6]);
		end
	end

	// go flag and completion flag
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			go_r       <= 1'b0;
			irq_flag_r <= 1'b0;
		end else if (i_clk_en) begin
			if (done || abort || !on_r) begin
				go_r <= 1'b0;
			end else if (start) begin
				go_r <= 1'b1;
			end
			if (done) begin
				irq_flag_r <= 1'b1;
			end else if (do_wr && i_wstrb_ok(wstrb_r) && hit(awaddr_r, apc_pkg::IDX_IRQ_STATUS)) begin
				irq_flag_r <= wdata_r[apc_pkg::IRQ_BIT];
			end
		end
	end

	// result pair, written by software or loaded on completion
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			res_hi_r <= 8'h0;
			res_lo_r <= 8'h0;
		end else if (i_clk_en) begin
			if (done) begin
				if (fmt_r) begin
					res_hi_r <= {6'h0, held_r[9:8]};
					res_lo_r <= held_r[7:0];
				end else begin
					res_hi_r <= held_r[9:2];
					res_lo_r <= {held_r[1:0], 6'h0};
				end
			end else if (do_wr && i_wstrb_ok(wstrb_r)) begin
				if (hit(awaddr_r, apc_pkg::IDX_RESULT_HIGH)) begin
					res_hi_r <= wdata_r[7:0];
				end
				if (hit(awaddr_r, apc_pkg::IDX_RESULT_LOW)) begin
					res_lo_r <= wdata_r[7:0];
				end
			end
		end
	end

	// conversion sequencer
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r        <= apc_pkg::APC_OFF;
			tad_cnt_r      <= 4'h0;
			held_r         <= 10'h0;
			o_hold_connect <= 1'b0;
			o_conv_busy    <= 1'b0;
			o_sample_ch    <= 3'h0;
		end else if (i_clk_en) begin
			o_sample_ch <= chan_r;
			if (!on_r) begin
				state_r        <= apc_pkg::APC_OFF;
				o_hold_connect <= 1'b0;
				o_conv_busy    <= 1'b0;
			end else begin
				case (state_r)
					apc_pkg::APC_OFF: begin
						state_r        <= apc_pkg::APC_ACQ;
						o_hold_connect <= 1'b1;
					end
					apc_pkg::APC_ACQ: begin
						if (start) begin
							held_r         <= i_sample_code;
							tad_cnt_r      <= 4'h0;
							state_r        <= apc_pkg::APC_CONV;
							o_hold_connect <= 1'b0;
							o_conv_busy    <= 1'b1;
						end
					end
					apc_pkg::APC_CONV: begin
						if (done || abort) begin
							tad_cnt_r   <= 4'h0;
							state_r     <= apc_pkg::APC_HOLDOFF;
							o_conv_busy <= 1'b0;
						end else if (tick) begin
							tad_cnt_r <= tad_cnt_r + 4'h1;
						end
					end
					apc_pkg::APC_HOLDOFF: begin
						if (tick && tad_cnt_r == apc_pkg::HOLDOFF_TADS - 4'h1) begin
							state_r        <= apc_pkg::APC_ACQ;
							o_hold_connect <= 1'b1;
						end else if (tick) begin
							tad_cnt_r <= tad_cnt_r + 4'h1;
						end
					end
					default: begin
						state_r <= apc_pkg::APC_OFF;
					end
				endcase
			end
		end
	end
endmodule : apc_top

/* tb/apc_checker.sv */
// concurrent checks on the converter control block ports
// assumes it is bound into apc_top and sees only its ports
`timescale 1ns/10ps
module apc_checker (
	input wire logic        i_ref_clk,      // clock
	input wire logic        i_reset_n,      // reset, low active
	input wire logic        i_arvalid,      // read address valid
	input wire logic        o_arready,      // read address ready
	input wire logic        o_rvalid,       // read data valid
	input wire logic [31:0] o_rdata,        // read data
	input wire logic        i_rready,       // read data ready
	input wire logic        o_bvalid,       // write response valid
	input wire logic [1:0]  o_bresp,        // write response
	input wire logic        i_bready,       // write response ready
	input wire logic        o_conv_busy,    // conversion running
	input wire logic        o_hold_connect, // capacitor on input
	input wire logic [4:0]  o_analog_sel,   // analog pins
	input wire logic        o_vref_pos_ext, // positive reference pin
	input wire logic        o_vref_neg_ext, // negative reference pin
	input wire logic [2:0]  o_analog_count, // analog count
	input wire logic [1:0]  o_ref_count     // reference count
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	ana_count_a: assert property (o_analog_count == 3'($countones(o_analog_sel)))
		else $error("analog count differs from analog pins");
	ref_count_a: assert property (o_ref_count == {1'b0, o_vref_pos_ext} + {1'b0, o_vref_neg_ext})
		else $error("reference count differs from reference pins");
	pos_ref_pin_a: assert property (o_vref_pos_ext |-> !o_analog_sel[3])
		else $error("positive reference pin still analog");
	neg_ref_pin_a: assert property (o_vref_neg_ext |-> o_vref_pos_ext && !o_analog_sel[2])
		else $error("negative reference without positive one");
	busy_open_a: assert property (o_conv_busy |-> !o_hold_connect)
		else $error("capacitor connected during conversion");
	holdoff_open_a: assert property ($fell(o_conv_busy) |-> !o_hold_connect [*4])
		else $error("acquisition before recovery");
	start_from_acq_a: assert property ($rose(o_conv_busy) |-> $past(o_hold_connect))
		else $error("conversion started outside acquisition");
	bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped early");
	read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read not answered next cycle");

	// main scenarios seen
	cover property ($rose(o_conv_busy));
	cover property ($fell(o_conv_busy) ##1 !o_hold_connect);
	cover property (o_vref_neg_ext);
endmodule : apc_checker

/* tb/apc_front_end_model.sv */
// analog pins and front end seen by the converter control block
// assumes the block captures the code when a conversion starts
`timescale 1ns/10ps
module apc_front_end_model (
	input  wire logic [2:0] i_sample_ch,   // channel on the mux
	output logic      [9:0] o_sample_code, // code of that channel
	output logic      [4:0] o_pin_level    // digital pin levels
);
	// code follows the pin whatever its direction
	assign o_sample_code = 10'h2c5 ^ {7'h0, i_sample_ch};
	// fixed pin pattern, analog pins must mask it
	assign o_pin_level = 5'h1b;
endmodule : apc_front_end_model

/* tb/test_apc_top.sv */
// self-checking bench for the converter control block
// assumes apc_top, apc_pkg, the front end model and the checker
`timescale 1ns/10ps
module test_apc_top;
	localparam logic [11:0] A_C0 = {2'h0, apc_pkg::IDX_CTRL_ZERO, 2'h0};   // control zero
	localparam logic [11:0] A_C1 = {2'h0, apc_pkg::IDX_CTRL_ONE, 2'h0};    // control one
	localparam logic [11:0] A_ST = {2'h0, apc_pkg::IDX_IRQ_STATUS, 2'h0};  // flag
	localparam logic [11:0] A_RH = {2'h0, apc_pkg::IDX_RESULT_HIGH, 2'h0}; // result high
	localparam logic [11:0] A_RL = {2'h0, apc_pkg::IDX_RESULT_LOW, 2'h0};  // result low
	localparam logic [11:0] A_PL = {2'h0, apc_pkg::IDX_PORT_LEVEL, 2'h0};  // pin levels
	localparam logic [11:0] A_EN = {2'h0, apc_pkg::IDX_IRQ_ENABLE, 2'h0};  // enable
	localparam logic [1:0]  OK = apc_pkg::RESP_OKAY;                       // okay
	// expected analog pins, positive and negative references per code
	localparam logic [4:0] MASK [16] = '{5'h1f, 5'h17, 5'h1f, 5'h17, 5'h0b, 5'h03, 5'h00, 5'h00,
		5'h13, 5'h1f, 5'h17, 5'h13, 5'h13, 5'h03, 5'h01, 5'h01};
	localparam logic [15:0] POS = 16'hbd2a;
	localparam logic [15:0] NEG = 16'hb900;

	logic        clk = 1'b0, rst_n = 1'b0;                                   // clock, reset
	logic        en = 1'b1;                                                  // clock enable
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;               // write side
	logic        arvalid = 1'b0, rready = 1'b0;                              // read side
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;                         // addresses
	logic [31:0] wdata = 32'h0;                                              // write data
	wire logic   awready, wready, bvalid, arready, rvalid, hold, busy, vpos, vneg;
	wire logic [1:0]  bresp, rresp, refc;
	wire logic [2:0]  ch, anc;
	wire logic [4:0]  asel, pins;
	wire logic [9:0]  code;
	wire logic [31:0] rdata;
	int num_errors = 0, total_checks = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	apc_top apc_top_i (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(en), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_pin_level(pins), .i_sample_code(code), .o_sample_ch(ch),
		.o_hold_connect(hold), .o_conv_busy(busy), .o_analog_sel(asel), .o_vref_pos_ext(vpos),
		.o_vref_neg_ext(vneg), .o_analog_count(anc), .o_ref_count(refc));
	apc_front_end_model apc_front_end_model_i (.i_sample_ch(ch), .o_sample_code(code), .o_pin_level(pins));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		total_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("unexpected at %0t: count %h outside %h to %h", $time, got, lo, hi);
		end
	endtask : chk_rng

	// write one byte register, hold each channel until taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	// read one byte register and compare it
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, {24'h0, exp});
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd

	// reset values and refused addresses
	task automatic t_reset;
		rd(A_C1, 8'h00, OK);
		chk({27'h0, asel}, 32'h1f);
		rd(12'h004, 8'h00, apc_pkg::RESP_SLVERR);
		wr(12'h07d, 8'h55, apc_pkg::RESP_SLVERR);
		rd(A_EN, 8'h00, OK);
		wr(A_EN, 8'h40, OK);
		rd(A_EN, 8'h40, OK);
	endtask : t_reset

	// reset in mid run clears control one and the enable again
	task automatic t_rerun;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
	endtask : t_rerun

	// every port code, with the unused bits written high
	task automatic t_decode;
		logic [4:0] m;
		for (int c = 0; c < 16; c++) begin
			m = MASK[c];
			wr(A_C1, {4'h3, 4'(c)}, OK);
			rd(A_C1, {4'h0, 4'(c)}, OK);
			chk({27'h0, asel}, {27'h0, m});
			chk({30'h0, vneg, vpos}, {30'h0, NEG[c], POS[c]});
			chk({27'h0, anc, refc}, {27'h0, 3'($countones(m)), {1'b0, NEG[c]} + {1'b0, POS[c]}});
			rd(A_PL, {3'h0, pins & ~m}, OK);
		end
	endtask : t_decode

	// one conversion: s is {halving, source}, c the channel, f the format
	task automatic t_conv(input logic [2:0] s, input int tad, input logic [2:0] c, input logic f);
		logic [9:0] v;
		int n;
		v = 10'h2c5 ^ {7'h0, c};
		wr(A_C1, {f, s[2], 6'h0}, OK);
		wr(A_ST, 8'h00, OK);
		wr(A_C0, {s[1:0], c, 3'h1}, OK);
		repeat (8) @(posedge clk); // acquisition before go
		wr(A_C0, {s[1:0], c, 3'h5}, OK);
		n = 0;
		while (busy) begin
			@(posedge clk);
			n++;
		end
		chk_rng(n, 9 * tad - 2, 9 * tad + 2);
		n = 0;
		while (!hold) begin
			@(posedge clk);
			n++;
		end
		chk_rng(n, 2 * tad - 2, 2 * tad + 2);
		rd(A_C0, {s[1:0], c, 3'h1}, OK);
		rd(A_ST, 8'h40, OK);
		rd(A_RH, f ? {6'h0, v[9:8]} : v[9:2], OK);
		rd(A_RL, f ? v[7:0] : {v[1:0], 6'h0}, OK);
	endtask : t_conv

	// go cleared in mid conversion at 64 clocks per bit period
	task automatic t_abort;
		int n;
		wr(A_C1, 8'h40, OK);
		wr(A_ST, 8'h00, OK);
		wr(A_C0, 8'h91, OK);
		repeat (8) @(posedge clk);
		wr(A_C0, 8'h95, OK);
		repeat (30) @(posedge clk);
		wr(A_C0, 8'h91, OK);
		chk({31'h0, busy}, 32'h0);
		n = 0;
		while (!hold) begin
			@(posedge clk);
			n++;
		end
		chk_rng(n, 126, 130);
		rd(A_ST, 8'h00, OK);
		rd(A_RH, 8'hb1, OK);
		rd(A_RL, 8'h00, OK);
	endtask : t_abort

	// go while the converter is off is dropped
	task automatic t_off;
		wr(A_C0, 8'h00, OK);
		wr(A_C0, 8'h04, OK);
		repeat (4) @(posedge clk);
		chk({31'h0, busy}, 32'h0);
		rd(A_C0, 8'h00, OK);
	endtask : t_off

	// enable low for 10 cycles stretches a 4-clock-period conversion by 10
	task automatic t_freeze;
		int n;
		wr(A_C0, 8'h01, OK);
		repeat (8) @(posedge clk);
		wr(A_C0, 8'h05, OK);
		en <= 1'b0;
		repeat (10) @(posedge clk);
		en <= 1'b1;
		n = 10;
		while (busy) begin
			@(posedge clk);
			n++;
		end
		chk_rng(n, 44, 48);
	endtask : t_freeze

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_decode;
		t_rerun;
		t_conv(3'b000, 2, 3'h0, 1'b0);
		t_conv(3'b100, 4, 3'h1, 1'b1);
		t_conv(3'b001, 8, 3'h2, 1'b0);
		t_conv(3'b101, 16, 3'h3, 1'b1);
		t_conv(3'b010, 32, 3'h4, 1'b0);
		t_conv(3'b110, 64, 3'h0, 1'b1);
		t_conv(3'b111, 400, 3'h1, 1'b0);
		t_abort;
		t_off;
		t_freeze;
		tally_and_finish;
	end

	// the run needs under 10000 cycles, so 20000 means a hang
	initial begin
		#200000;
		num_errors++;
		tally_and_finish;
	end
endmodule : test_apc_top

bind apc_top apc_checker apc_checker_i (.i_ref_clk, .i_reset_n, .i_arvalid, .o_arready, .o_rvalid,
	.o_rdata, .i_rready, .o_bvalid, .o_bresp, .i_bready, .o_conv_busy, .o_hold_connect, .o_analog_sel,
	.o_vref_pos_ext, .o_vref_neg_ext, .o_analog_count, .o_ref_count);
